/* File: dcpm_cke_power_manager.sv */
`timescale 1ns/1ns
// Summary of operation
// - Tri-state outputs toward empty module positions
// - Unpopulated rank: chip-select, clock-enable undriven
// - Reset assumes all ranks populated, driven
// - Four independent clock-enable outputs
// - Clock-enable low during power-up
// - Clock-enable low until configuration write
// - Self-refresh in C3/C6 without pending requests
// - Graphics and I/O traffic block self-refresh except on suspend
// - Suspend: drain, self-refresh, clock-enable held low
// - Idle ranks powered down individually
// - Setting selects active or precharge power-down
// - Precharge mode closes pages before power-down
// - Wake all ranks for refresh, then down
// - Per-slot clock, termination control; per-rank select, enable control
// - Unused channel signals all disabled
// - Unused signals: driver off; receiver, DLL off only when no slot is used
// - Gate input path once no slot is used
module dcpm_cke_power_manager
   import dcpm_pkg::*;
#(
   parameter int INIT_CYC = DCPM_INIT_CYC // Least clock-enable low time in core cycles
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic link_clk_i,
   // Configuration
   input wire logic cfg_wr_i,
   input wire logic [3:0] rank_absent_i,
   input wire logic chan_used_i,
   input wire logic dpd_en_i,
   input wire logic pd_mode_pre_i,
   // Power state and traffic
   input wire logic [2:0] pkg_cstate_i,
   input wire logic mem_req_pending_i,
   input wire logic gfx_active_i,
   input wire logic io_traffic_i,
   input wire logic suspend_to_ram_state_i,
   input wire logic [3:0] rank_idle_i,
   input wire logic [3:0] rank_pages_open_i,
   input wire logic refresh_req_i,
   input wire logic refresh_done_i,
   // Core-side answers
   output logic [3:0] precharge_req_o,
   output logic refresh_go_o,
   output logic [3:0] cmd_allow_o,
   output logic drain_req_o,
   output logic sref_active_o,
   output logic str_ack_o,
   // Link-side command and pad signals
   input wire logic [3:0] cmd_cs_n_i,
   input wire logic [1:0] odt_i,
   input wire logic [15:0] pad_dq_i,
   output logic [3:0] sdram_clock_enable_out_o,
   output logic [3:0] cke_oe_n_o,
   output logic [3:0] cs_n_o,
   output logic [3:0] cs_oe_n_o,
   output logic [1:0] odt_o,
   output logic [1:0] odt_oe_n_o,
   output logic [1:0] mclk_en_o,
   output logic rx_en_o,
   output logic dll_en_o,
   output logic [15:0] rd_data_o
);
   // Both halves of a slot empty
   function automatic logic slot_absent(input logic [3:0] a, input int s);
      slot_absent = a[2*s] & a[2*s+1];
   endfunction

   // Core domain state
   dcpm_state_t state_r, state_nxt;      // Sequencer
   logic [3:0] absent_r;                 // Ranks marked absent
   logic chan_used_r;                    // Channel in use
   logic cfg_done_r;                     // Configuration written
   logic [DCPM_INIT_CNT_W-1:0] init_cnt_r; // Time since reset
   logic [3:0] pd_r;                     // Rank in power-down
   logic [3:0] cke_want_r, cke_want_nxt; // Clock-enable request to link
   logic [3:0] cke_back_s;               // Clock-enable seen at the pins
   // Link domain state
   logic [3:0] want_s;                   // Synchronised request
   logic [3:0] absent_s;                 // Synchronised absent mask
   logic chan_off_s;                     // Synchronised channel unused; clears to in use so reset drives pins
   wire chan_s = ~chan_off_s;            // Channel in use at the link
   logic [15:0] dq_s;                    // Synchronised pad data

   // Decoded conditions
   wire init_tmr_done = (init_cnt_r == INIT_CYC[DCPM_INIT_CNT_W-1:0]);
   wire init_ok = cfg_done_r & init_tmr_done;
   wire deep_idle = (pkg_cstate_i == DCPM_CST_C3) | (pkg_cstate_i == DCPM_CST_C6);
   wire sref_cond = deep_idle & ~mem_req_pending_i & ~gfx_active_i & ~io_traffic_i;
   wire [3:0] present = ~absent_r;
   wire all_up = &(cke_back_s | absent_r);
   wire in_run = (state_r == DCPM_ST_RUN);
   wire in_ref = (state_r == DCPM_ST_REF);
   wire in_drain = (state_r == DCPM_ST_DRAIN); // Pending cycles still being served

   // Configuration latch; absent marks only through a firmware write
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         absent_r <= DCPM_ABSENT_RST;
         chan_used_r <= DCPM_CHAN_USED_RST;
         cfg_done_r <= 1'b0;
      end else if (cfg_wr_i) begin
         absent_r <= rank_absent_i;
         chan_used_r <= chan_used_i;
         cfg_done_r <= 1'b1;
      end
   end

   // Least low time counter, saturates
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         init_cnt_r <= '0;
      end else if (!init_tmr_done) begin
         init_cnt_r <= init_cnt_r + 1'b1;
      end
   end

   // Sequencer next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         DCPM_ST_INIT: begin
            if (init_ok) begin
               state_nxt = DCPM_ST_EXIT;
            end
         end
         DCPM_ST_RUN: begin
            if (suspend_to_ram_state_i) begin
               state_nxt = DCPM_ST_DRAIN;
            end else if (sref_cond) begin
               state_nxt = DCPM_ST_SREF;
            end else if (dpd_en_i && refresh_req_i) begin
               state_nxt = DCPM_ST_REF;
            end
         end
         DCPM_ST_DRAIN: begin
            if (!mem_req_pending_i) begin
               state_nxt = DCPM_ST_SREF;
            end
         end
         DCPM_ST_SREF: begin
            if (!suspend_to_ram_state_i && !sref_cond) begin
               state_nxt = DCPM_ST_EXIT;
            end
         end
         DCPM_ST_EXIT: begin
            if (all_up) begin
               state_nxt = DCPM_ST_RUN;
            end
         end
         DCPM_ST_REF: begin
            if (refresh_done_i) begin
               state_nxt = DCPM_ST_RUN;
            end
         end
         default: begin
            state_nxt = DCPM_ST_INIT;
         end
      endcase
   end

   // Sequencer register
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= DCPM_ST_INIT;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Per-rank dynamic power-down
   generate
      for (genvar i = 0; i < DCPM_NUM_RANKS; i++) begin : g_rank
         wire may_drop = dpd_en_i & rank_idle_i[i] & (~pd_mode_pre_i | ~rank_pages_open_i[i]);
         // Close pages first when precharge mode is chosen
         assign precharge_req_o[i] = in_run & dpd_en_i & pd_mode_pre_i & rank_idle_i[i]
                                     & rank_pages_open_i[i] & ~pd_r[i];
         // Command allowed only once the pin is seen high
         assign cmd_allow_o[i] = (in_run | in_drain) & ~pd_r[i] & cke_want_r[i] & cke_back_s[i];
         always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               pd_r[i] <= 1'b0;
            end else if (in_ref) begin
               pd_r[i] <= refresh_done_i;
            end else if (!in_run || !rank_idle_i[i]) begin
               pd_r[i] <= 1'b0;
            end else if (may_drop) begin
               pd_r[i] <= 1'b1;
            end
         end
      end
   endgenerate

   // Clock-enable request per state
   always_comb begin
      cke_want_nxt = 4'h0;
      case (state_r)
         DCPM_ST_RUN: begin
            cke_want_nxt = ~pd_r & present;
         end
         DCPM_ST_EXIT, DCPM_ST_REF, DCPM_ST_DRAIN: begin
            cke_want_nxt = present;
         end
         default: begin
            cke_want_nxt = 4'h0;
         end
      endcase
   end

   // Registered request feeds the crossing
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cke_want_r <= DCPM_CKE_RST;
      end else begin
         cke_want_r <= cke_want_nxt;
      end
   end

   // Core-side status
   assign drain_req_o = (state_r == DCPM_ST_DRAIN);
   assign sref_active_o = (state_r == DCPM_ST_SREF);
   assign str_ack_o = sref_active_o & suspend_to_ram_state_i & ~|cke_back_s;
   assign refresh_go_o = refresh_req_i & all_up & ((in_run & ~dpd_en_i) | in_ref);

   // Crossings: requests and config into link, pin state back to core
   dcpm_sync2 #(.WIDTH(9)) u_to_link (
      .clk_i(link_clk_i),
      .rstn_i(rstn_i),
      .d_i({~chan_used_r, absent_r, cke_want_r}),
      .q_o({chan_off_s, absent_s, want_s})
   );
   dcpm_sync2 #(.WIDTH(4)) u_to_core (
      .clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .d_i(sdram_clock_enable_out_o),
      .q_o(cke_back_s)
   );
   dcpm_sync2 #(.WIDTH(DCPM_DQ_W)) u_pad_dq (
      .clk_i(link_clk_i),
      .rstn_i(rstn_i),
      .d_i(pad_dq_i),
      .q_o(dq_s)
   );

   // Link-side enables
   wire [3:0] rank_off = absent_s | {4{~chan_s}};
   wire [1:0] slot_off;
   generate
      for (genvar s = 0; s < DCPM_NUM_SLOTS; s++) begin : g_slot
         assign slot_off[s] = slot_absent(absent_s, s) | ~chan_s;
      end
   endgenerate
   wire any_used = ~&slot_off;

   // Pin drivers on the link clock
   always_ff @(posedge link_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sdram_clock_enable_out_o <= DCPM_CKE_RST;
         cke_oe_n_o <= 4'h0;
         cs_n_o <= 4'hf;
         cs_oe_n_o <= 4'h0;
         odt_o <= 2'h0;
         odt_oe_n_o <= 2'h0;
         mclk_en_o <= 2'h3;
         rx_en_o <= 1'b1;
         dll_en_o <= 1'b1;
      end else begin
         sdram_clock_enable_out_o <= want_s & ~rank_off;
         cke_oe_n_o <= rank_off;
         cs_n_o <= cmd_cs_n_i | rank_off;
         cs_oe_n_o <= rank_off;
         odt_o <= odt_i & ~slot_off;
         odt_oe_n_o <= slot_off;
         mclk_en_o <= ~slot_off;
         rx_en_o <= any_used;
         dll_en_o <= any_used;
      end
   end

   // Receiver path gated while disabled
   always_ff @(posedge link_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_data_o <= 16'h0000;
      end else begin
         rd_data_o <= dq_s & {DCPM_DQ_W{rx_en_o}};
      end
   end

   // Checks, core clock
   sequence s_drained;
      state_r == DCPM_ST_DRAIN && !mem_req_pending_i;
   endsequence
   sequence s_in_sref_low;
      state_r == DCPM_ST_SREF ##1 cke_want_r == 4'h0;
   endsequence
   init_hold_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !cfg_done_r |-> cke_want_r == 4'h0) else $error("clock enable requested before configuration");
   str_enter_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      s_drained |=> s_in_sref_low) else $error("suspend did not reach self-refresh with enable low");
   drain_wait_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      state_r == DCPM_ST_DRAIN && mem_req_pending_i |=> state_r == DCPM_ST_DRAIN)
      else $error("left drain with requests pending");
   sref_enter_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      in_run && sref_cond && !suspend_to_ram_state_i |=> state_r == DCPM_ST_SREF)
      else $error("deep idle did not enter self-refresh");
   sref_block_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      in_run && (gfx_active_i || io_traffic_i) && !suspend_to_ram_state_i |=> state_r != DCPM_ST_SREF)
      else $error("self-refresh entered with traffic active");
   pre_close_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      $rose(pd_r[0]) && $past(in_run) && $past(pd_mode_pre_i) |-> !$past(rank_pages_open_i[0]))
      else $error("precharge power-down with open pages");
   ref_wake_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      refresh_go_o && dpd_en_i |-> in_ref && ((cke_want_r & cke_back_s) | absent_r) == 4'hf)
      else $error("refresh with ranks asleep");
   ref_down_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      in_ref && refresh_done_i |=> pd_r == 4'hf && state_r == DCPM_ST_RUN)
      else $error("ranks not returned to power-down after refresh");
   cmd_cke_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      |cmd_allow_o |-> (cmd_allow_o & ~cke_back_s) == 4'h0 && state_r != DCPM_ST_EXIT && !sref_active_o)
      else $error("command allowed with enable low");
   // Checks, link clock
   absent_oe_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
      absent_s[2] |=> cke_oe_n_o[2] && cs_oe_n_o[2] && !sdram_clock_enable_out_o[2])
      else $error("absent rank still driven");
   slot_clk_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
      absent_s[3:2] == 2'h3 |=> !mclk_en_o[1] && odt_oe_n_o[1]) else $error("empty slot still clocked");
   chan_off_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
      !chan_s |=> !rx_en_o && !dll_en_o && cke_oe_n_o == 4'hf) else $error("unused channel not disabled");
   rx_gate_a: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
      !rx_en_o |=> rd_data_o == 16'h0000) else $error("gated receiver passed data");
endmodule // dcpm_cke_power_manager

/* File: dcpm_pkg.sv */
// Constants shared by the clock-enable power manager
package dcpm_pkg;
   // Geometry
   localparam int DCPM_NUM_RANKS = 4;      // Independent clock-enable outputs
   localparam int DCPM_NUM_SLOTS = 2;      // Module slots, two ranks each
   localparam int DCPM_DQ_W = 16;          // Data pad width seen by the receiver gate
   localparam int DCPM_CST_W = 3;          // Package idle state code width
   // Package idle state codes
   localparam logic [2:0] DCPM_CST_C3 = 3'h3;
   localparam logic [2:0] DCPM_CST_C6 = 3'h6;
   // Reset values
   localparam logic [3:0] DCPM_ABSENT_RST = 4'h0; // Every rank assumed present
   localparam logic DCPM_CHAN_USED_RST = 1'h1;    // Channel assumed in use
   localparam logic [3:0] DCPM_CKE_RST = 4'h0;    // Clock enable low
   // Timing: least clock-enable low time after reset
   localparam int DCPM_CLK_NS = 40;
   localparam int DCPM_T_INIT_NS = 200000;
   localparam int DCPM_INIT_CYC = (DCPM_T_INIT_NS + DCPM_CLK_NS - 1) / DCPM_CLK_NS;
   localparam int DCPM_INIT_CNT_W = 16;
   // Core-side sequencing states
   typedef enum logic [5:0] {
      DCPM_ST_INIT = 6'h01,
      DCPM_ST_RUN = 6'h02,
      DCPM_ST_DRAIN = 6'h04,
      DCPM_ST_SREF = 6'h08,
      DCPM_ST_EXIT = 6'h10,
      DCPM_ST_REF = 6'h20
   } dcpm_state_t;
endpackage

/* File: dcpm_sync2.sv */
`timescale 1ns/1ns
// Two-flop level synchroniser
module dcpm_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r; // First stage, read only by second stage

   // Both stages clear to zero on reset
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta_r <= '0;
         q_o <= '0;
      end else begin
         meta_r <= d_i;
         q_o <= meta_r;
      end
   end
endmodule // dcpm_sync2

/* File: dcpm_sdram_model.sv */
`timescale 1ns/1ns
// Behavioural SDRAM ranks on the far side of the pads
module dcpm_sdram_model
   import dcpm_pkg::*;
(
   input wire logic link_clk_i,
   input wire logic rstn_i,
   input wire logic [3:0] cke_i,
   input wire logic [3:0] cke_oe_n_i,
   output logic [15:0] pad_dq_o
);
   logic [15:0] data_r; // Word the ranks put on the pads
   wire logic awake; // Some driven rank has its clock enable high
   assign awake = |(cke_i & ~cke_oe_n_i & {DCPM_NUM_RANKS{1'b1}});
   // Awake ranks return a counting pattern; asleep, the pads float and change every cycle
   always_ff @(posedge link_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         data_r <= 16'h5a5a;
      end else if (awake) begin
         data_r <= data_r + 16'h0001;
      end else begin
         data_r <= ~data_r; // No stable level while clock enable is low
      end
   end
   assign pad_dq_o = data_r;
endmodule // dcpm_sdram_model

/* File: tb_dcpm_cke_power_manager.sv */
`timescale 1ns/1ns
// Self-checking bench for the clock-enable power manager
module tb_dcpm_cke_power_manager
   import dcpm_pkg::*;
;
   logic core_clk_i = 1'b0, link_clk_i = 1'b0, rstn_i = 1'b0, cfg_wr_i = 1'b0;
   logic [3:0] rank_absent_i = 4'h0, rank_idle_i = 4'h0, rank_pages_open_i = 4'h0, cmd_cs_n_i = 4'hf;
   logic chan_used_i = 1'b1, dpd_en_i = 1'b0, pd_mode_pre_i = 1'b0, mem_req_pending_i = 1'b0;
   logic gfx_active_i = 1'b0, io_traffic_i = 1'b0, suspend_to_ram_state_i = 1'b0;
   logic refresh_req_i = 1'b0, refresh_done_i = 1'b0;
   logic [2:0] pkg_cstate_i = 3'h0;
   logic [1:0] odt_i = 2'h0;
   logic [15:0] pad_dq_i, rd_data_o;
   logic [3:0] precharge_req_o, cmd_allow_o, cke_o, cke_oe_n_o, cs_n_o, cs_oe_n_o;
   logic refresh_go_o, drain_req_o, sref_active_o, str_ack_o, rx_en_o, dll_en_o;
   logic [1:0] odt_o, odt_oe_n_o, mclk_en_o;
   int miscompares = 0, compares = 0, cyc = 0;
   logic [2:0] codes [3] = '{DCPM_CST_C3, DCPM_CST_C6, 3'h2}; // Deep and shallow idle codes
   // Clocks: core 40 ns, link 80 ns with an unrelated phase
   always #20 core_clk_i = ~core_clk_i;
   initial #13 forever #40 link_clk_i = ~link_clk_i;
   dcpm_cke_power_manager #(.INIT_CYC(8)) dut_u (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .link_clk_i(link_clk_i), .cfg_wr_i(cfg_wr_i), .rank_absent_i(rank_absent_i), .chan_used_i(chan_used_i),
      .dpd_en_i(dpd_en_i), .pd_mode_pre_i(pd_mode_pre_i), .pkg_cstate_i(pkg_cstate_i),
      .mem_req_pending_i(mem_req_pending_i), .gfx_active_i(gfx_active_i), .io_traffic_i(io_traffic_i),
      .suspend_to_ram_state_i(suspend_to_ram_state_i), .rank_idle_i(rank_idle_i),
      .rank_pages_open_i(rank_pages_open_i), .refresh_req_i(refresh_req_i), .refresh_done_i(refresh_done_i),
      .precharge_req_o(precharge_req_o), .refresh_go_o(refresh_go_o), .cmd_allow_o(cmd_allow_o),
      .drain_req_o(drain_req_o), .sref_active_o(sref_active_o), .str_ack_o(str_ack_o),
      .cmd_cs_n_i(cmd_cs_n_i), .odt_i(odt_i), .pad_dq_i(pad_dq_i), .sdram_clock_enable_out_o(cke_o),
      .cke_oe_n_o(cke_oe_n_o), .cs_n_o(cs_n_o), .cs_oe_n_o(cs_oe_n_o), .odt_o(odt_o),
      .odt_oe_n_o(odt_oe_n_o), .mclk_en_o(mclk_en_o), .rx_en_o(rx_en_o), .dll_en_o(dll_en_o),
      .rd_data_o(rd_data_o));
   dcpm_sdram_model mem_u (.link_clk_i(link_clk_i), .rstn_i(rstn_i), .cke_i(cke_o),
      .cke_oe_n_i(cke_oe_n_o), .pad_dq_o(pad_dq_i));
   // Verdict and end of run
   task automatic finish_test();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // One comparison
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Let a change cross both domains: a few link edges plus the core handshake
   task automatic settle();
      repeat (20) @(posedge core_clk_i);
   endtask
   // Firmware configuration write, one core cycle
   task automatic cfg_write(input logic [3:0] absent, input logic used);
      @(posedge core_clk_i);
      cfg_wr_i <= 1'b1;
      rank_absent_i <= absent;
      chan_used_i <= used;
      @(posedge core_clk_i);
      cfg_wr_i <= 1'b0;
   endtask
   // Hang guard
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         finish_test();
      end
   end
   // Command logic drives selects and termination on the link clock
   always @(posedge link_clk_i) begin
      cmd_cs_n_i <= (cyc > 20) ? 4'h0 : 4'hf;
      odt_i <= 2'h3;
   end
   initial begin
      repeat (6) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      chk(16'(cke_o), 16'h0);
      chk(16'({cke_oe_n_o, cs_oe_n_o}), 16'h0);
      chk(16'({mclk_en_o, rx_en_o}), 16'h7);
      @(posedge link_clk_i);
      #1;
      chk(16'({cke_oe_n_o, cs_oe_n_o, mclk_en_o, rx_en_o}), 16'h7);
      settle();
      chk(16'(cke_o), 16'h0);
      cfg_write(4'hc, 1'b1);
      settle();
      chk(16'(cke_o[1:0]), 16'h3);
      chk(16'(cmd_allow_o[1:0]), 16'h3);
      chk(16'({cke_oe_n_o, cs_oe_n_o}), 16'hcc);
      chk(16'({odt_oe_n_o, mclk_en_o}), 16'h9);
      settle();
      chk(16'(cs_n_o), 16'hc);
      chk(16'(odt_o[0]), 16'h1);
      // Dynamic power-down, active then precharge mode
      @(posedge core_clk_i);
      dpd_en_i <= 1'b1;
      rank_idle_i <= 4'h1;
      rank_pages_open_i <= 4'h1;
      settle();
      chk(16'({cke_o[1:0], cmd_allow_o[0]}), 16'h4);
      @(posedge core_clk_i);
      rank_idle_i <= 4'h0;
      settle();
      chk(16'({cke_o[1:0], cmd_allow_o[0]}), 16'h7);
      @(posedge core_clk_i);
      pd_mode_pre_i <= 1'b1;
      rank_idle_i <= 4'h2;
      rank_pages_open_i <= 4'h2;
      settle();
      chk(16'({precharge_req_o[1], cke_o[1]}), 16'h3);
      @(posedge core_clk_i);
      rank_pages_open_i <= 4'h0;
      settle();
      chk(16'({precharge_req_o[1], cke_o[1]}), 16'h0);
      // Refresh wakes every rank and puts them down again
      @(posedge core_clk_i);
      rank_idle_i <= 4'h3;
      settle();
      chk(16'(cke_o[1:0]), 16'h0);
      @(posedge core_clk_i);
      refresh_req_i <= 1'b1;
      settle();
      chk(16'({cke_o[1:0], refresh_go_o}), 16'h7);
      @(posedge core_clk_i);
      refresh_req_i <= 1'b0;
      refresh_done_i <= 1'b1;
      @(posedge core_clk_i);
      refresh_done_i <= 1'b0;
      settle();
      chk(16'({cke_o[1:0], refresh_go_o}), 16'h0);
      @(posedge core_clk_i);
      rank_idle_i <= 4'h0;
      dpd_en_i <= 1'b0;
      settle();
      // Conditional self-refresh for each idle code, and what blocks it
      foreach (codes[i]) begin
         @(posedge core_clk_i);
         pkg_cstate_i <= codes[i];
         settle();
         chk(16'(sref_active_o), (i < 2) ? 16'h1 : 16'h0);
         chk(16'(cke_o[1:0]), (i < 2) ? 16'h0 : 16'h3);
         @(posedge core_clk_i);
         gfx_active_i <= 1'b1;
         settle();
         chk(16'({sref_active_o, cke_o[1:0], cmd_allow_o[1:0]}), 16'hf);
         @(posedge core_clk_i);
         gfx_active_i <= 1'b0;
         io_traffic_i <= 1'b1;
         settle();
         chk(16'(sref_active_o), 16'h0);
         @(posedge core_clk_i);
         io_traffic_i <= 1'b0;
         mem_req_pending_i <= 1'b1;
         settle();
         chk(16'(sref_active_o), 16'h0);
         @(posedge core_clk_i);
         mem_req_pending_i <= 1'b0;
         pkg_cstate_i <= 3'h0;
         settle();
      end
      // Suspend: drain first, then self-refresh with clock enable held low
      @(posedge core_clk_i);
      mem_req_pending_i <= 1'b1;
      suspend_to_ram_state_i <= 1'b1;
      settle();
      chk(16'({drain_req_o, sref_active_o, cke_o[1:0], cmd_allow_o[1:0]}), 16'h2f);
      @(posedge core_clk_i);
      mem_req_pending_i <= 1'b0;
      settle();
      chk(16'({sref_active_o, str_ack_o, cke_o[1:0]}), 16'hc);
      settle();
      chk(16'(cke_o[1:0]), 16'h0);
      @(posedge core_clk_i);
      suspend_to_ram_state_i <= 1'b0;
      settle();
      chk(16'({cke_o[1:0], cmd_allow_o[1:0]}), 16'hf);
      // Whole channel unused: everything off, input path gated
      cfg_write(4'h0, 1'b0);
      settle();
      chk(16'({rx_en_o, dll_en_o, mclk_en_o}), 16'h0);
      chk(16'(cke_oe_n_o), 16'hf);
      chk(rd_data_o, 16'h0);
      finish_test();
   end
endmodule // tb_dcpm_cke_power_manager
